// ===== core/pcbm_pkg.sv
// constants for the panel cpu bus master
// assumes a 25 MHz ref_clk and a 16-bit 80-series panel
package pcbm_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  // ------------------------------------------------------------
  // timing in ns and derived cycle counts (rounded up)
  // ------------------------------------------------------------
  localparam int unsigned WRITE_LOW_MIN_NS = 50;
  localparam int unsigned WRITE_HIGH_MIN_NS = 50;
  localparam int unsigned WRITE_CYCLE_MIN_NS = 100;
  localparam int unsigned READ_LOW_MIN_NS = 150;
  localparam int unsigned READ_HIGH_MIN_NS = 150;
  localparam int unsigned READ_CYCLE_MIN_NS = 300;
  localparam int unsigned PANEL_RESET_NS = 10000;
  localparam int unsigned PANEL_WAKE_NS = 10000;
  localparam int unsigned WRITE_LOW_CYC =
    (WRITE_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WRITE_HIGH_CYC =
    (WRITE_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_LOW_CYC =
    (READ_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_HIGH_CYC =
    (READ_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PANEL_RESET_CYC =
    (PANEL_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PANEL_WAKE_CYC =
    (PANEL_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 9;
  // request word: [17] read, [16] index_or_data_select, [15:0] data
  localparam int unsigned REQ_READ_BIT = 17;
  localparam int unsigned REQ_SEL_BIT = 16;
  localparam int unsigned REQ_W = 18;

  typedef enum logic [2:0] {
    PCBM_ST_RESET = 3'b000,
    PCBM_ST_WAKE = 3'b001,
    PCBM_ST_IDLE = 3'b011,
    PCBM_ST_LOW = 3'b010,
    PCBM_ST_HIGH = 3'b110
  } pcbm_state_t;
endpackage

// ===== core/pcbm_fifo.sv
// request fifo for the panel cpu bus master
// assumes one clock, source and sink on ref_clk
`timescale 1ns/1ns
`default_nettype none
module pcbm_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  always_comb begin
    in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
    out_valid = wp_r != rp_r;
    out_data = mem_r[rp_r[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule // pcbm_fifo
`default_nettype wire

// ===== core/pcbm_top.sv
// panel cpu bus master: queues requests and strobes them to the panel
// assumes pin inputs synchronous to ref_clk; bus wire resolved outside
`timescale 1ns/1ns
`default_nettype none
module pcbm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic req_index_or_data_select,
  input wire logic [pcbm_pkg::WORD_W-1:0] req_data,
  output logic rsp_valid,
  output logic [pcbm_pkg::WORD_W-1:0] rsp_data,
  input wire logic boost_enable_req,
  output logic boost_supply_on,
  output logic panel_ready,
  output logic panel_cs_n,
  output logic index_or_data_select,
  output logic panel_rd_n,
  output logic panel_wr_n,
  output logic panel_reset_n,
  input wire logic [pcbm_pkg::WORD_W-1:0] panel_word_bus_in,
  output logic [pcbm_pkg::WORD_W-1:0] panel_word_bus_out,
  output logic panel_word_bus_oe
);
  import pcbm_pkg::*;

  logic fifo_ready;
  logic req_take;
  logic q_valid;
  logic q_pop;
  logic [REQ_W-1:0] q_data;

  // ------------------------------------------------------------
  // request queue
  // ------------------------------------------------------------
  // bursts wait here while the panel strobes slowly
  pcbm_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(req_take),
    .in_ready(fifo_ready),
    .in_data({req_read, req_index_or_data_select, req_data}),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_data)
  );

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  pcbm_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic rd_op_r, rd_op_nxt;
  logic cs_n_r, cs_n_nxt, sel_r, sel_nxt;
  logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
  logic res_n_r, res_n_nxt, oe_r, oe_nxt, rdy_r, rdy_nxt;
  logic [WORD_W-1:0] dout_r, dout_nxt, rsp_r, rsp_nxt;
  logic rsp_v_r, rsp_v_nxt, boost_r, boost_nxt, req_rdy_r, req_rdy_nxt;

  // ------------------------------------------------------------
  // request acceptance
  // ------------------------------------------------------------
  // a word is taken only while req_ready shows, so a word held over
  // the forced-low cycle after an accept is not queued twice
  always_comb begin
    req_take = req_valid && req_rdy_r;
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_op_nxt = rd_op_r;
    cs_n_nxt = cs_n_r;
    sel_nxt = sel_r;
    rd_n_nxt = rd_n_r;
    wr_n_nxt = wr_n_r;
    res_n_nxt = res_n_r;
    oe_nxt = oe_r;
    rdy_nxt = rdy_r;
    dout_nxt = dout_r;
    rsp_nxt = rsp_r;
    rsp_v_nxt = 1'b0;
    q_pop = 1'b0;
    boost_nxt = boost_enable_req;
    req_rdy_nxt = fifo_ready && !req_take;
    case (st_r)
      PCBM_ST_RESET: begin
        // bus stays idle while the panel is held in reset
        res_n_nxt = 1'b0;
        if (cnt_r == CNT_W'(PANEL_RESET_CYC - 1)) begin
          res_n_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = PCBM_ST_WAKE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      PCBM_ST_WAKE: begin
        // settle time before the first access
        if (cnt_r == CNT_W'(PANEL_WAKE_CYC - 1)) begin
          cnt_nxt = '0;
          rdy_nxt = 1'b1;
          st_nxt = PCBM_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      PCBM_ST_IDLE: begin
        cs_n_nxt = 1'b1;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        oe_nxt = 1'b0;
        if (q_valid) begin
          // one request per visit; strobe and word leave together
          q_pop = 1'b1;
          rd_op_nxt = q_data[REQ_READ_BIT];
          sel_nxt = q_data[REQ_SEL_BIT];
          dout_nxt = q_data[WORD_W-1:0];
          cs_n_nxt = 1'b0;
          // exactly one strobe goes low
          rd_n_nxt = !q_data[REQ_READ_BIT];
          wr_n_nxt = q_data[REQ_READ_BIT];
          oe_nxt = !q_data[REQ_READ_BIT];
          cnt_nxt = '0;
          st_nxt = PCBM_ST_LOW;
        end
      end
      PCBM_ST_LOW: begin
        // read word taken on the last low cycle, strobe still low
        cnt_nxt = cnt_r + 1'b1;
        if (rd_op_r && cnt_r == CNT_W'(READ_LOW_CYC - 1)) begin
          rsp_nxt = panel_word_bus_in;
          rsp_v_nxt = 1'b1;
          rd_n_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = PCBM_ST_HIGH;
        end else if (!rd_op_r && cnt_r == CNT_W'(WRITE_LOW_CYC - 1)) begin
          wr_n_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = PCBM_ST_HIGH;
        end
      end
      PCBM_ST_HIGH: begin
        // data held through rising edge, released afterwards
        cs_n_nxt = 1'b1;
        oe_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if ((rd_op_r && cnt_r == CNT_W'(READ_HIGH_CYC - 1)) ||
            (!rd_op_r && cnt_r == CNT_W'(WRITE_HIGH_CYC - 1))) begin
          cnt_nxt = '0;
          st_nxt = PCBM_ST_IDLE;
        end
      end
      default: begin
        st_nxt = PCBM_ST_RESET;
        cnt_nxt = '0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= PCBM_ST_RESET;
      cnt_r <= '0;
      rd_op_r <= 1'b0;
      cs_n_r <= 1'b1;
      sel_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      res_n_r <= 1'b0;
      oe_r <= 1'b0;
      rdy_r <= 1'b0;
      dout_r <= '0;
      rsp_r <= '0;
      rsp_v_r <= 1'b0;
      boost_r <= 1'b0;
      req_rdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_op_r <= rd_op_nxt;
      cs_n_r <= cs_n_nxt;
      sel_r <= sel_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      res_n_r <= res_n_nxt;
      oe_r <= oe_nxt;
      rdy_r <= rdy_nxt;
      dout_r <= dout_nxt;
      rsp_r <= rsp_nxt;
      rsp_v_r <= rsp_v_nxt;
      boost_r <= boost_nxt;
      req_rdy_r <= req_rdy_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    req_ready = req_rdy_r;
    rsp_valid = rsp_v_r;
    rsp_data = rsp_r;
    boost_supply_on = boost_r;
    panel_ready = rdy_r;
    panel_cs_n = cs_n_r;
    index_or_data_select = sel_r;
    panel_rd_n = rd_n_r;
    panel_wr_n = wr_n_r;
    panel_reset_n = res_n_r;
    panel_word_bus_out = dout_r;
    panel_word_bus_oe = oe_r;
  end
endmodule // pcbm_top
`default_nettype wire

// ===== testbench/pcbm_checker.sv
// checker: panel bus timing and strobe relations
// assumes pcbm_top ports, one ref_clk domain
`timescale 1ns/1ns
`default_nettype none
module pcbm_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic boost_enable_req,
  input wire logic boost_supply_on,
  input wire logic panel_ready,
  input wire logic rsp_valid,
  input wire logic panel_cs_n,
  input wire logic panel_rd_n,
  input wire logic panel_wr_n,
  input wire logic panel_word_bus_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------
  // strobe shapes
  // ----------------------------
  sequence s_wr_pulse;
    !panel_wr_n [*2] ##1 panel_wr_n [*2];
  endsequence
  sequence s_rd_pulse;
    !panel_rd_n [*4] ##1 panel_rd_n [*4];
  endsequence
  a_no_dual_strobe: assert property (
    panel_rd_n || panel_wr_n) else $error("both strobes low");
  a_idle_strobes_high: assert property (
    panel_cs_n |-> panel_rd_n && panel_wr_n) else $error("strobe w/o cs");
  a_write_pulse_len: assert property (
    $fell(panel_wr_n) |-> s_wr_pulse) else $error("write pulse width");
  a_read_pulse_len: assert property (
    $fell(panel_rd_n) |-> s_rd_pulse) else $error("read pulse width");
  a_write_drives_bus: assert property (
    !panel_wr_n |-> panel_word_bus_oe && !panel_cs_n)
    else $error("write without drive");
  a_read_bus_free: assert property (
    !panel_rd_n |-> !panel_word_bus_oe) else $error("bus driven in read");
  a_rsp_after_read: assert property (
    rsp_valid |-> $rose(panel_rd_n)) else $error("rsp without read");
  a_reset_before_bus: assert property (
    !panel_ready |-> panel_cs_n) else $error("access before ready");
  a_boost_follows: assert property (
    $changed(boost_enable_req) |=> boost_supply_on == $past(boost_enable_req))
    else $error("boost not following");
endmodule // pcbm_checker
bind pcbm_top pcbm_checker u_pcbm_checker (.ref_clk, .rst,
  .boost_enable_req, .boost_supply_on, .panel_ready, .rsp_valid,
  .panel_cs_n, .panel_rd_n, .panel_wr_n, .panel_word_bus_oe);
`default_nettype wire

// ===== testbench/pcbm_panel_model.sv
// panel controller model: index, status and one graphics word
// assumes strobes from pcbm_top; bus resolved by the bench
`timescale 1ns/1ns
`default_nettype none
module pcbm_panel_model #(
  parameter logic [15:0] STATUS = 16'h5a3c
) (
  input wire logic cs_n,
  input wire logic sel,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] wr_word,
  output logic [15:0] rd_word
);
  logic [15:0] idx_r = 16'h0000;
  logic [15:0] panel_graphics_ram_r = 16'h0000;
  // latch on the rising write strobe, only when selected
  always @(posedge wr_n) begin
    if (!cs_n && sel) panel_graphics_ram_r <= wr_word;
    if (!cs_n && !sel) idx_r <= wr_word;
  end
  // status mixes in the index so index writes are visible
  always_comb begin
    if (!cs_n && !rd_n) begin
      rd_word = sel ? panel_graphics_ram_r : (STATUS ^ idx_r);
    end else begin
      rd_word = ~(sel ? panel_graphics_ram_r : (STATUS ^ idx_r));
    end
  end
endmodule // pcbm_panel_model
`default_nettype wire

// ===== testbench/tb_top.sv
// bench for pcbm_top with a panel model on the far side
// assumes 25 MHz ref_clk; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pcbm_pkg::*;
  localparam logic [15:0] STAT = 16'h5a3c;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic req_sel = 1'b0;
  logic [15:0] req_data = 16'h0000;
  logic boost_req = 1'b0;
  logic req_ready, rsp_valid, boost_on, panel_ready, cs_n, sel, rd_n, wr_n;
  logic reset_n, oe;
  logic [15:0] rsp_data, bus_out, bus_in, model_word;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int waits, mx;
  always #20 ref_clk = ~ref_clk;
  assign bus_in = oe ? bus_out : model_word;
  pcbm_top u_pcbm_top (.ref_clk, .rst, .req_valid, .req_ready, .req_read,
    .req_index_or_data_select(req_sel), .req_data, .rsp_valid, .rsp_data,
    .boost_enable_req(boost_req), .boost_supply_on(boost_on), .panel_ready,
    .panel_cs_n(cs_n), .index_or_data_select(sel), .panel_rd_n(rd_n),
    .panel_wr_n(wr_n), .panel_reset_n(reset_n), .panel_word_bus_in(bus_in),
    .panel_word_bus_out(bus_out), .panel_word_bus_oe(oe));
  pcbm_panel_model #(.STATUS(STAT)) u_pcbm_panel_model (.cs_n, .sel, .rd_n,
    .wr_n, .wr_word(bus_out), .rd_word(model_word));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // queue one request; valid stays up for a back-to-back caller
  task automatic push(input logic r, input logic s, input logic [15:0] d);
    req_valid = 1'b1;
    req_read = r;
    req_sel = s;
    req_data = d;
    waits = 0;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk);
      waits++;
    end
    @(negedge ref_clk);
  endtask
  task automatic read(input logic s, input logic [15:0] exp);
    push(1'b1, s, 16'h0000);
    req_valid = 1'b0;
    repeat (400) begin
      @(negedge ref_clk);
      if (rsp_valid === 1'b1) break;
    end
    chk(rsp_valid, 1'b1);
    chk(rsp_data, exp);
  endtask
  task automatic t_reset();
    int n;
    chk({reset_n, cs_n, rd_n, wr_n, oe, boost_on}, 16'h001c);
    rst = 1'b0;
    n = 0;
    while (reset_n !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n), 16'(PANEL_RESET_CYC));
    while (panel_ready !== 1'b1 && n < 1000) begin
      chk(cs_n, 1'b1);
      @(negedge ref_clk);
      n++;
    end
    chk(panel_ready, 1'b1);
    chk(16'(n), 16'(PANEL_RESET_CYC + PANEL_WAKE_CYC));
  endtask
  task automatic t_regs();
    push(1'b0, 1'b0, 16'h0005);
    push(1'b0, 1'b1, 16'hbeef);
    read(1'b0, STAT ^ 16'h0005);
    @(negedge ref_clk);
    read(1'b1, 16'hbeef);
  endtask
  task automatic t_fill();
    mx = 0;
    @(negedge ref_clk);
    for (int i = 0; i < 32; i++) begin
      push(1'b0, 1'b1, 16'h1000 + 16'(i));
      if (waits > mx) mx = waits;
    end
    chk(mx > 1, 1'b1);
    read(1'b1, 16'h101f);
  endtask
  task automatic t_boost();
    boost_req = 1'b1;
    @(negedge ref_clk);
    chk(boost_on, 1'b1);
    boost_req = 1'b0;
    @(negedge ref_clk);
    chk(boost_on, 1'b0);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    t_reset();
    t_regs();
    t_fill();
    t_boost();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
